/* shared/eip_pkg.sv */
// shared constants and types of the startup image programmer
package eip_pkg;
    localparam int         ADDR_W       = 8;
    localparam logic [7:0] OFF_PROG_CNT = 8'h10;
    localparam logic [7:0] OFF_ADR_USE  = 8'h12;
    localparam logic [7:0] OFF_REV_USE  = 8'h13;
    localparam logic [7:0] OFF_OVL_CTRL = 8'h14;
    localparam logic [7:0] OFF_ACT_BASE = 8'h20;
    localparam logic [7:0] OFF_STORE    = 8'hab;
    localparam logic [7:0] OFF_PTR_HI   = 8'had;
    localparam logic [7:0] OFF_PTR_LO   = 8'hae;
    localparam logic [7:0] OFF_BUF_DATA = 8'hb0;
    localparam logic [7:0] OFF_UNLOCK   = 8'hb4;
    localparam int         BIT_OVL      = 7;
    localparam int         BIT_COMMIT   = 6;
    localparam int         BIT_BUSY     = 2;
    localparam int         BIT_ERASE    = 1;
    localparam int         BIT_PROG     = 0;
    localparam int         ADR_LSB      = 3;
    localparam int         PTR_HI_W     = 5;
    localparam int         PTR_W        = 13;
    localparam logic [7:0] UNLOCK_KEY   = 8'hea;
    localparam logic [7:0] LOCK_VAL     = 8'h00;
    localparam logic [7:0] ERASED_BYTE  = 8'hff;
    localparam logic [7:0] CMD_ERASE_PROG = 8'h03;
    localparam logic [PTR_W-1:0] IMG_ADR = 13'h000c;
    localparam logic [PTR_W-1:0] IMG_REV = 13'h000d;
    localparam logic [PTR_W-1:0] IMG_OVL = 13'h000e;
    localparam int         PROG_TIME_MS = 500;
    localparam int         CLK_MHZ      = 100;
    localparam int         PROG_CYC     = PROG_TIME_MS * 1000 * CLK_MHZ;
    typedef enum logic [1:0] {
        EIP_OP_WRITE,
        EIP_OP_READ,
        EIP_OP_PROGRAM
    } eip_op_e;
endpackage

/* shared/eip_if.sv */
// register port between host controller and device
`timescale 1ns/1ps
`default_nettype none
interface eip_if;
    logic [eip_pkg::ADDR_W-1:0] addr;
    logic [7:0]                 wdata;
    logic                       wr;
    logic                       rd;
    logic [7:0]                 rdata;
    modport dev  (input addr, input wdata, input wr, input rd, output rdata);
    modport host (output addr, output wdata, output wr, output rd,
                  input rdata);
endinterface
`default_nettype wire

/* src/eip_device.sv */
// device end: staging buffer, nonvolatile store and startup overlay
// Functional notes
// RQ1: commit request copies active registers into buffer
// RQ2: commit request bit self-clears when copy done
// RQ3: commit never touches address and revision bytes
// RQ4: direct buffer writes leave active registers alone
// RQ5: overlay enable bit applies image at startup
// RQ6: store commands need unlock key 234 held
// RQ7: erase plus program together copy buffer to store
// RQ8: host sends unlock and command back to back
// RQ9: host keeps serial bus quiet during pair
// RQ10: busy flag while programming; host polls or waits
// RQ11: host waits for busy clear before next step
// RQ12: host relocks store by writing zero key
// RQ13: power-on after good program bumps program count
// RQ14: power-on loads active registers when overlay set
// RQ15: pointer upper five bits from high register
// RQ16: pointer lower eight bits from low register
// RQ17: data register write stores byte at pointer
// RQ18: image byte 0x0C holds address upper bits
// RQ19: address bits in use readable, read-only
// RQ20: image byte 0x0D revision, in-use copy readable
// RQ21: address and revision change only via image
// RQ22: overlay overwrites startup settings with image
// RQ23: commands without key are ignored
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module eip_device #(
    parameter int         ACT_N    = 12,
    parameter int         BUF_N    = 16,
    parameter int         PROG_CYC = eip_pkg::PROG_CYC,
    parameter logic [4:0] ADR_DEF  = 5'h19
) (
    input  wire logic           clk,
    input  wire logic           reset_n,
    eip_if.dev                  bus,
    input  wire logic           por,
    output logic [ACT_N*8-1:0]  active_settings,
    output logic                overlay_enable,
    output logic                store_busy
);
    localparam int BI_W = $clog2(BUF_N);

    if (ACT_N < 1 || ACT_N > 12 || BUF_N < 15 || PROG_CYC < 1) begin : g_chk
        $error("eip_device: unsupported parameter values");
    end

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_COMMIT,
        ST_PROG
    } eip_dev_st_e;

    typedef struct packed {
        eip_dev_st_e                st;
        logic [BI_W-1:0]            idx;
        logic [31:0]                tmr;
        logic [ACT_N-1:0][7:0]      act;
        logic [BUF_N-1:0][7:0]      sbuf;
        logic [BUF_N-1:0][7:0]      nv;
        logic                       ovl;
        logic                       commit;
        logic                       busy;
        logic                       good;
        logic [7:0]                 key;
        logic [7:0]                 cnt;
        logic [7:0]                 adr;
        logic [7:0]                 rev;
        logic [eip_pkg::PTR_HI_W-1:0] ph;
        logic [7:0]                 pl;
        logic [7:0]                 rdata;
    } eip_dev_s;

    eip_dev_s s_q;
    eip_dev_s s_d;

    function automatic logic [BUF_N-1:0][7:0] factory_image();
        logic [BUF_N-1:0][7:0] img;
        img = '0;
        img[eip_pkg::IMG_ADR] = {ADR_DEF, 3'b000};
        return img;
    endfunction

    function automatic logic [7:0] read_mux(input eip_dev_s s,
                                            input logic [7:0] a);
        logic [7:0] r;
        r = 8'h00;
        if (a == eip_pkg::OFF_PROG_CNT) begin
            r = s.cnt;
        end else if (a == eip_pkg::OFF_ADR_USE) begin
            r = s.adr;
        end else if (a == eip_pkg::OFF_REV_USE) begin
            r = s.rev;
        end else if (a == eip_pkg::OFF_OVL_CTRL) begin
            r[eip_pkg::BIT_OVL] = s.ovl;
        end else if (a == eip_pkg::OFF_STORE) begin
            r[eip_pkg::BIT_COMMIT] = s.commit;
            r[eip_pkg::BIT_BUSY]   = s.busy;
        end else if (a == eip_pkg::OFF_PTR_HI) begin
            r[eip_pkg::PTR_HI_W-1:0] = s.ph;
        end else if (a == eip_pkg::OFF_PTR_LO) begin
            r = s.pl;
        end else if (a == eip_pkg::OFF_UNLOCK) begin
            r = s.key;
        end else if (a >= eip_pkg::OFF_ACT_BASE &&
                     a < eip_pkg::OFF_ACT_BASE + 8'(ACT_N)) begin
            r = s.act[a - eip_pkg::OFF_ACT_BASE];
        end
        return r;
    endfunction

    always_comb begin
        logic [eip_pkg::PTR_W-1:0] ptr;
        ptr = {s_q.ph, s_q.pl};
        s_d = s_q;
        s_d.rdata = 8'h00;
        if (bus.rd) begin
            s_d.rdata = read_mux(s_q, bus.addr);
        end
        if (bus.wr) begin
            if (bus.addr == eip_pkg::OFF_OVL_CTRL) begin
                s_d.ovl = bus.wdata[eip_pkg::BIT_OVL]; // see RQ5
            end else if (bus.addr == eip_pkg::OFF_PTR_HI) begin
                s_d.ph = bus.wdata[eip_pkg::PTR_HI_W-1:0]; // see RQ15
            end else if (bus.addr == eip_pkg::OFF_PTR_LO) begin
                s_d.pl = bus.wdata; // see RQ16
            end else if (bus.addr == eip_pkg::OFF_BUF_DATA) begin
                // only the buffer changes, active settings keep running
                if (ptr < eip_pkg::PTR_W'(BUF_N)) begin
                    s_d.sbuf[ptr[BI_W-1:0]] = bus.wdata; // see RQ17, RQ4
                end
            end else if (bus.addr == eip_pkg::OFF_UNLOCK) begin
                s_d.key = bus.wdata;
            end else if (bus.addr == eip_pkg::OFF_STORE) begin
                if (s_q.st == ST_IDLE && bus.wdata[eip_pkg::BIT_COMMIT]) begin
                    s_d.commit = 1'b1;
                    s_d.st     = ST_COMMIT;
                    s_d.idx    = '0;
                end else if (s_q.st == ST_IDLE &&
                             bus.wdata[eip_pkg::BIT_ERASE] &&
                             bus.wdata[eip_pkg::BIT_PROG] &&
                             s_q.key == eip_pkg::UNLOCK_KEY) begin
                    // see RQ6, RQ7, RQ23
                    s_d.st   = ST_PROG;
                    s_d.busy = 1'b1; // see RQ10
                    s_d.tmr  = '0;
                    s_d.nv   = {BUF_N{eip_pkg::ERASED_BYTE}};
                end
            end else if (bus.addr >= eip_pkg::OFF_ACT_BASE &&
                         bus.addr < eip_pkg::OFF_ACT_BASE + 8'(ACT_N)) begin
                s_d.act[bus.addr - eip_pkg::OFF_ACT_BASE] = bus.wdata;
            end
        end
        case (s_q.st)
            ST_COMMIT: begin
                // active bytes map below the address and revision bytes
                s_d.sbuf[s_q.idx] = s_q.act[s_q.idx]; // see RQ1, RQ3
                s_d.idx = s_q.idx + 1'b1;
                if (s_q.idx == BI_W'(ACT_N - 1)) begin
                    s_d.sbuf[eip_pkg::IMG_OVL][eip_pkg::BIT_OVL] = s_q.ovl;
                    s_d.commit = 1'b0; // see RQ2
                    s_d.st     = ST_IDLE;
                end
            end
            ST_PROG: begin
                s_d.tmr = s_q.tmr + 32'd1;
                if (s_q.tmr == 32'(PROG_CYC - 1)) begin
                    s_d.nv   = s_q.sbuf; // see RQ7
                    s_d.busy = 1'b0; // see RQ10
                    s_d.good = 1'b1;
                    s_d.st   = ST_IDLE;
                end
            end
            default: begin
            end
        endcase
        if (por) begin
            s_d.cnt  = s_q.cnt + {7'd0, s_q.good}; // see RQ13
            s_d.good = 1'b0;
            // in-use address and revision come only from the image
            s_d.adr  = {s_q.nv[eip_pkg::IMG_ADR][7:eip_pkg::ADR_LSB],
                        3'b000}; // see RQ18, RQ19, RQ21
            s_d.rev  = s_q.nv[eip_pkg::IMG_REV]; // see RQ20
            s_d.ovl  = s_q.nv[eip_pkg::IMG_OVL][eip_pkg::BIT_OVL];
            s_d.act  = '0;
            if (s_q.nv[eip_pkg::IMG_OVL][eip_pkg::BIT_OVL]) begin
                s_d.act = s_q.nv[ACT_N-1:0]; // see RQ14, RQ22
            end
            s_d.st     = ST_IDLE;
            s_d.commit = 1'b0;
            s_d.busy   = 1'b0;
            s_d.key    = eip_pkg::LOCK_VAL;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_q      <= '0;
            s_q.st   <= ST_IDLE;
            s_q.nv   <= factory_image();
            s_q.adr  <= {ADR_DEF, 3'b000};
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.rdata       = s_q.rdata;
    assign active_settings = s_q.act;
    assign overlay_enable  = s_q.ovl;
    assign store_busy      = s_q.busy;
endmodule
`default_nettype wire

/* src/eip_host.sv */
// host end: register access and the unlock, program, poll, relock sequence
`timescale 1ns/1ps
`default_nettype none
module eip_host (
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    eip_if.host                              bus,
    input  wire logic                        cmd_valid,
    input  wire eip_pkg::eip_op_e            cmd_op,
    input  wire logic [eip_pkg::ADDR_W-1:0]  cmd_addr,
    input  wire logic [7:0]                  cmd_data,
    output logic                             cmd_ready,
    output logic                             resp_valid,
    output logic [7:0]                       resp_data
);
    typedef enum logic [2:0] {
        HS_IDLE,
        HS_FINISH,
        HS_RD_WAIT,
        HS_RD_DATA,
        HS_CMD,
        HS_POLL,
        HS_POLL_WAIT,
        HS_POLL_DATA
    } eip_host_st_e;

    typedef struct packed {
        eip_host_st_e               st;
        logic                       wr;
        logic                       rd;
        logic [eip_pkg::ADDR_W-1:0] addr;
        logic [7:0]                 wdata;
        logic                       rv;
        logic [7:0]                 rdat;
    } eip_host_s;

    eip_host_s h_q;
    eip_host_s h_d;

    always_comb begin
        h_d    = h_q;
        h_d.wr = 1'b0;
        h_d.rd = 1'b0;
        h_d.rv = 1'b0;
        case (h_q.st)
            HS_IDLE: begin
                if (cmd_valid) begin
                    h_d.addr  = cmd_addr;
                    h_d.wdata = cmd_data;
                    if (cmd_op == eip_pkg::EIP_OP_READ) begin
                        h_d.rd = 1'b1;
                        h_d.st = HS_RD_WAIT;
                    end else if (cmd_op == eip_pkg::EIP_OP_PROGRAM) begin
                        h_d.wr    = 1'b1;
                        h_d.addr  = eip_pkg::OFF_UNLOCK;
                        h_d.wdata = eip_pkg::UNLOCK_KEY; // see RQ6
                        h_d.st    = HS_CMD;
                    end else begin
                        h_d.wr = 1'b1;
                        h_d.st = HS_FINISH;
                    end
                end
            end
            HS_CMD: begin
                // next cycle after the unlock, nothing in between
                h_d.wr    = 1'b1;
                h_d.addr  = eip_pkg::OFF_STORE;
                h_d.wdata = eip_pkg::CMD_ERASE_PROG; // see RQ7, RQ8, RQ9
                h_d.st    = HS_POLL;
            end
            HS_POLL: begin
                h_d.rd   = 1'b1;
                h_d.addr = eip_pkg::OFF_STORE; // see RQ10
                h_d.st   = HS_POLL_WAIT;
            end
            HS_POLL_WAIT: begin
                // read data stand only in the cycle after the strobe
                h_d.st = HS_POLL_DATA;
            end
            HS_POLL_DATA: begin
                if (bus.rdata[eip_pkg::BIT_BUSY]) begin
                    h_d.rd   = 1'b1;
                    h_d.addr = eip_pkg::OFF_STORE;
                    h_d.st   = HS_POLL_WAIT; // see RQ11
                end else begin
                    h_d.wr    = 1'b1;
                    h_d.addr  = eip_pkg::OFF_UNLOCK;
                    h_d.wdata = eip_pkg::LOCK_VAL; // see RQ12
                    h_d.rdat  = 8'h00;
                    h_d.st    = HS_FINISH;
                end
            end
            HS_RD_WAIT: begin
                h_d.st = HS_RD_DATA;
            end
            HS_RD_DATA: begin
                h_d.rdat = bus.rdata;
                h_d.rv   = 1'b1;
                h_d.st   = HS_IDLE;
            end
            HS_FINISH: begin
                h_d.rv = 1'b1;
                h_d.st = HS_IDLE;
            end
            default: begin
                h_d.st = HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            h_q    <= '0;
            h_q.st <= HS_IDLE;
        end else begin
            h_q <= h_d;
        end
    end

    assign bus.wr     = h_q.wr;
    assign bus.rd     = h_q.rd;
    assign bus.addr   = h_q.addr;
    assign bus.wdata  = h_q.wdata;
    assign cmd_ready  = (h_q.st == HS_IDLE);
    assign resp_valid = h_q.rv;
    assign resp_data  = h_q.rdat;
endmodule
`default_nettype wire

/* bench/eip_bus_sva.sv */
// register port checker for the startup image programmer
`timescale 1ns/1ps
`default_nettype none
module eip_bus_sva (
    input wire logic                       clk,
    input wire logic                       reset_n,
    input wire logic [eip_pkg::ADDR_W-1:0] addr,
    input wire logic [7:0]                 wdata,
    input wire logic                       wr,
    input wire logic                       rd,
    input wire logic [7:0]                 rdata
);
    logic key_q;
    logic prog_q;
    logic rd_st;
    assign rd_st = rd && addr == eip_pkg::OFF_STORE;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // tracks an unlock, program, poll sequence of the host
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            key_q  <= 1'b0;
            prog_q <= 1'b0;
        end else begin
            key_q <= wr && addr == eip_pkg::OFF_UNLOCK
                     && wdata == eip_pkg::UNLOCK_KEY;
            if (wr && addr == eip_pkg::OFF_UNLOCK)
                prog_q <= 1'b0;
            else if (key_q && wr && addr == eip_pkg::OFF_STORE
                     && wdata == eip_pkg::CMD_ERASE_PROG)
                prog_q <= 1'b1;
        end
    end
    sequence s_key;
        wr && addr == eip_pkg::OFF_UNLOCK && wdata == eip_pkg::UNLOCK_KEY;
    endsequence
    sequence s_pair;
        wr && addr == eip_pkg::OFF_STORE && wdata == eip_pkg::CMD_ERASE_PROG;
    endsequence
    property p_one_strobe; !(wr && rd); endproperty
    a_one_strobe: assert property (p_one_strobe)
        else $error("read and write strobes together");
    property p_rdata_idle; rdata != 8'h00 |-> $past(rd); endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside its slot");
    property p_pair; s_key |=> s_pair; endproperty
    a_pair: assert property (p_pair)
        else $error("unlock not followed by erase and program");
    property p_poll_start; s_key ##1 s_pair |=> rd_st; endproperty
    a_poll_start: assert property (p_poll_start)
        else $error("no busy poll after command");
    property p_busy_seen; s_key ##1 s_pair ##1 rd_st |=> rdata[2]; endproperty
    a_busy_seen: assert property (p_busy_seen)
        else $error("busy flag not set after command");
    property p_poll_again;
        prog_q && rd_st ##1 rdata[eip_pkg::BIT_BUSY] |=> rd_st;
    endproperty
    a_poll_again: assert property (p_poll_again)
        else $error("host moved on while busy");
    property p_relock;
        prog_q && rd_st ##1 !rdata[eip_pkg::BIT_BUSY]
            |=> wr && addr == eip_pkg::OFF_UNLOCK
                && wdata == eip_pkg::LOCK_VAL;
    endproperty
    a_relock: assert property (p_relock)
        else $error("store not relocked after program");
    property p_cmd_bits; rd_st |=> rdata[1:0] == 2'b00; endproperty
    a_cmd_bits: assert property (p_cmd_bits)
        else $error("erase or program bit reads back set");
    property p_adr_low;
        rd && addr == eip_pkg::OFF_ADR_USE |=> rdata[2:0] == 3'b000;
    endproperty
    a_adr_low: assert property (p_adr_low)
        else $error("address low bits not zero");
    property p_wo_data;
        rd && addr == eip_pkg::OFF_BUF_DATA |=> rdata == 8'h00;
    endproperty
    a_wo_data: assert property (p_wo_data)
        else $error("buffer data register reads nonzero");
    c_program: cover property (s_key ##1 s_pair);
    c_commit: cover property (wr && addr == eip_pkg::OFF_STORE && wdata[6]);
    c_relock: cover property (prog_q && wr && addr == eip_pkg::OFF_UNLOCK);
    c_unmapped: cover property (rd && addr == 8'h11);
endmodule
`default_nettype wire

/* bench/tb.sv */
// self-checking bench joining the host and device ends
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct {
        eip_pkg::eip_op_e op;
        logic [7:0]       a;
        logic [7:0]       d;
        logic [7:0]       e;
    } eip_row_s;
    localparam eip_pkg::eip_op_e WO = eip_pkg::EIP_OP_WRITE;
    localparam eip_pkg::eip_op_e RO = eip_pkg::EIP_OP_READ;
    logic             clk = 1'b0;
    logic             reset_n = 1'b0;
    logic             por = 1'b0;
    logic             cmd_valid = 1'b0;
    eip_pkg::eip_op_e cmd_op = WO;
    logic [7:0]       cmd_addr = 8'h00;
    logic [7:0]       cmd_data = 8'h00;
    logic             cmd_ready;
    logic             resp_valid;
    logic [7:0]       resp_data;
    logic [95:0]      act;
    logic             ovl;
    logic             busy;
    logic [7:0]       r;
    int               fails = 0;
    int               samples_checked = 0;
    eip_row_s rows [16] = '{
        '{RO, 8'h10, 8'h00, 8'h00}, '{RO, 8'h12, 8'h00, 8'hc8},
        '{RO, 8'h13, 8'h00, 8'h00}, '{WO, 8'h12, 8'h55, 8'h00},
        '{RO, 8'h12, 8'h00, 8'hc8}, '{WO, 8'h13, 8'h77, 8'h00},
        '{RO, 8'h13, 8'h00, 8'h00}, '{WO, 8'h14, 8'h80, 8'h00},
        '{RO, 8'h14, 8'h00, 8'h80}, '{RO, 8'h11, 8'h00, 8'h00},
        '{WO, 8'hb4, 8'h5a, 8'h00}, '{RO, 8'hb4, 8'h00, 8'h5a},
        '{WO, 8'hb0, 8'h33, 8'h00}, '{RO, 8'hb0, 8'h00, 8'h00},
        '{WO, 8'h10, 8'h99, 8'h00}, '{RO, 8'h10, 8'h00, 8'h00}};
    eip_if bus ();
    eip_device #(.ACT_N(12), .BUF_N(16), .PROG_CYC(20)) u_eip_device (
        .clk(clk), .reset_n(reset_n), .bus(bus), .por(por),
        .active_settings(act), .overlay_enable(ovl), .store_busy(busy));
    eip_host u_eip_host (
        .clk(clk), .reset_n(reset_n), .bus(bus), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .cmd_ready(cmd_ready), .resp_valid(resp_valid),
        .resp_data(resp_data));
    eip_bus_sva u_eip_bus_sva (
        .clk(clk), .reset_n(reset_n), .addr(bus.addr), .wdata(bus.wdata),
        .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata));
    always #5 clk = ~clk;
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input eip_pkg::eip_op_e op, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op    <= op;
        cmd_addr  <= a;
        cmd_data  <= d;
        @(posedge clk);
        cmd_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (resp_valid !== 1'b1 && n < 200);
        if (n >= 200) begin
            fails++;
            report_and_stop();
        end
        q = resp_data;
    endtask
    task automatic put_reg(input logic [7:0] a, input logic [7:0] d);
        xfer(WO, a, d, r);
    endtask
    task automatic get_reg(input logic [7:0] a, input logic [7:0] e);
        xfer(RO, a, 8'h00, r);
        chk(r, e);
    endtask
    task automatic pulse_por();
        @(posedge clk);
        por <= 1'b1;
        @(posedge clk);
        por <= 1'b0;
    endtask
    initial begin
        int i;
        logic [7:0] st;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        foreach (rows[k]) begin
            xfer(rows[k].op, rows[k].a, rows[k].d, r);
            if (rows[k].op == RO)
                chk(r, rows[k].e);
        end
        // command under a wrong key, then a power cycle
        put_reg(eip_pkg::OFF_STORE, eip_pkg::CMD_ERASE_PROG);
        get_reg(eip_pkg::OFF_STORE, 8'h00);
        pulse_por();
        get_reg(eip_pkg::OFF_PROG_CNT, 8'h00);
        chk({7'h00, ovl}, 8'h00);
        for (i = 0; i < 12; i++)
            put_reg(eip_pkg::OFF_ACT_BASE + i[7:0], 8'h10 + i[7:0]);
        put_reg(eip_pkg::OFF_OVL_CTRL, 8'h80);
        // direct buffer writes, one beyond the buffer
        put_reg(eip_pkg::OFF_PTR_HI, 8'h00);
        put_reg(eip_pkg::OFF_PTR_LO, 8'h0c);
        put_reg(eip_pkg::OFF_BUF_DATA, 8'ha8);
        put_reg(eip_pkg::OFF_PTR_LO, 8'h0d);
        put_reg(eip_pkg::OFF_BUF_DATA, 8'h5a);
        put_reg(eip_pkg::OFF_PTR_HI, 8'h01);
        put_reg(eip_pkg::OFF_BUF_DATA, 8'hee);
        chk(act[7:0], 8'h10);
        get_reg(eip_pkg::OFF_ACT_BASE, 8'h10);
        // commit, watch the request bit clear by itself
        put_reg(eip_pkg::OFF_STORE, 8'h40);
        xfer(RO, eip_pkg::OFF_STORE, 8'h00, st);
        chk(st & 8'h40, 8'h40);
        i = 0;
        while (st[eip_pkg::BIT_COMMIT] === 1'b1 && i < 20) begin
            xfer(RO, eip_pkg::OFF_STORE, 8'h00, st);
            i++;
        end
        if (st[eip_pkg::BIT_COMMIT] !== 1'b0) begin
            fails++;
            report_and_stop();
        end
        chk(st, 8'h00);
        xfer(eip_pkg::EIP_OP_PROGRAM, 8'h00, 8'h00, st);
        chk(st, 8'h00);
        chk({7'h00, busy}, 8'h00);
        put_reg(eip_pkg::OFF_ACT_BASE, 8'h00);
        pulse_por();
        get_reg(eip_pkg::OFF_PROG_CNT, 8'h01);
        get_reg(eip_pkg::OFF_ADR_USE, 8'ha8);
        get_reg(eip_pkg::OFF_REV_USE, 8'h5a);
        get_reg(eip_pkg::OFF_ACT_BASE, 8'h10);
        chk(act[95:88], 8'h1b);
        chk({7'h00, ovl}, 8'h01);
        pulse_por();
        get_reg(eip_pkg::OFF_PROG_CNT, 8'h01);
        // reset in mid-run restores the factory image
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        chk({6'h00, cmd_ready, resp_valid}, 8'h02);
        chk({7'h00, ovl}, 8'h00);
        chk({7'h00, busy}, 8'h00);
        get_reg(eip_pkg::OFF_ADR_USE, 8'hc8);
        get_reg(eip_pkg::OFF_PROG_CNT, 8'h00);
        report_and_stop();
    end
endmodule
`default_nettype wire
